// *** src/usart_core.sv ***
// Asynchronous serial transceiver core with its three control and status registers
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
module usart_core
   import usart_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rstn,
   input  wire usart_pkg::reg_req_t req,
   output logic [7:0]            rdata,
   input  wire logic             baud_tick16,
   input  wire usart_pkg::line_in_t  line_in,
   output usart_pkg::line_out_t  line_out,
   output logic                  sync_mode
);
   import usart_pkg::*;

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] ctrl;
   logic [7:0] intclk;
   logic       spare;
   logic       attention_enable;
   logic       tx_empty_flag;
   logic       rx_full_flag;
   logic       overrun_flag;
   logic       framing_flag;
   logic       parity_err_flag;
   logic       rx_ninth_bit;
   logic       rx_break_status;
   logic       tx_active;
   logic [7:0] tx_holding_reg;
   logic [7:0] rx_holding_reg;

   logic [1:0] fmt;
   logic       nine_bit;
   logic       par_on;
   logic [3:0] data_bits;
   assign fmt       = {ctrl[BIT_FRAME_LEN_HIGH], ctrl[BIT_FRAME_LEN_LOW]};
   assign nine_bit  = fmt[1];
   assign par_on    = ctrl[BIT_PARITY_ENABLE] && !nine_bit;
   assign data_bits = (fmt == FMT_SEVEN) ? 4'h7 : (nine_bit ? 4'h9 : 4'h8);
   assign sync_mode = intclk[BIT_SYNC_MODE];

   // Parity of a data word under the current select bits
   function automatic logic parity_of(input logic [8:0] d, input logic [1:0] sel);
      logic x;
      x = ^d;
      case (sel)
         2'h0:    parity_of = ~x;
         2'h1:    parity_of = x;
         2'h2:    parity_of = 1'b1;
         default: parity_of = 1'b0;
      endcase
   endfunction

   logic [1:0] par_sel;
   assign par_sel = {ctrl[BIT_PARITY_SEL_HIGH], ctrl[BIT_PARITY_SEL_LOW]};

   // ------------------------------------------------------------
   // Pin synchronisers and clock select
   // ------------------------------------------------------------
   logic [1:0] rx_sync;
   logic [2:0] ck_sync;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_sync <= 2'h3;
         ck_sync <= 3'h0;
      end else begin
         rx_sync <= {rx_sync[0], line_in.serial_in_pin};
         ck_sync <= {ck_sync[1:0], line_in.ext_clock_pin};
      end
   end

   logic ext_tick;
   logic tx_tick;
   logic rx_tick;
   assign ext_tick = ck_sync[1] && !ck_sync[2];
   assign tx_tick  = intclk[BIT_TX_EXT_CLOCK] ? ext_tick : baud_tick16;
   assign rx_tick  = intclk[BIT_RX_EXT_CLOCK] ? ext_tick : baud_tick16;

   logic tx_line;
   logic rx_line;
   assign rx_line = (fmt == FMT_LOOP) ? tx_line : rx_sync[1];

   // ------------------------------------------------------------
   // Register access
   // ------------------------------------------------------------
   logic wr_ctrl;
   logic wr_rxstat;
   logic wr_intclk;
   logic wr_txbuf;
   logic rd_rxstat;
   logic rd_rxbuf;
   assign wr_ctrl   = req.wr && req.addr == ADDR_CTRL_STATUS;
   assign wr_rxstat = req.wr && req.addr == ADDR_RX_STATUS;
   assign wr_intclk = req.wr && req.addr == ADDR_INT_CLK_SEL;
   assign wr_txbuf  = req.wr && req.addr == ADDR_TX_HOLD;
   assign rd_rxstat = req.rd && req.addr == ADDR_RX_STATUS;
   assign rd_rxbuf  = req.rd && req.addr == ADDR_RX_HOLD;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl   <= RESET_CTRL;
         intclk <= RESET_INTCLK;
         spare  <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl <= req.wdata;
         end
         if (wr_intclk) begin
            intclk <= req.wdata;
         end
         if (wr_rxstat) begin
            spare <= req.wdata[BIT_SPARE];
         end
      end
   end

   logic [7:0] ctrl_view;
   logic [7:0] rxstat_view;
   always_comb begin
      ctrl_view                = ctrl;
      ctrl_view[BIT_ERROR_ANY] = overrun_flag | framing_flag | parity_err_flag;
      ctrl_view[BIT_RX_FULL]   = rx_full_flag;
      ctrl_view[BIT_TX_EMPTY]  = tx_empty_flag;
      rxstat_view = {overrun_flag, framing_flag, parity_err_flag, spare,
                     rx_ninth_bit, attention_enable, tx_active, rx_break_status};
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (req.rd) begin
         case (req.addr)
            ADDR_CTRL_STATUS: rdata <= ctrl_view;
            ADDR_RX_STATUS:   rdata <= rxstat_view;
            ADDR_INT_CLK_SEL: rdata <= intclk;
            ADDR_TX_HOLD:     rdata <= tx_holding_reg;
            ADDR_RX_HOLD:     rdata <= rx_holding_reg;
            default:          rdata <= 8'h00;
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   tx_state_t  tx_state;
   logic [8:0] tx_shifter;
   logic [3:0] tx_tickcnt;
   logic [3:0] tx_bitcnt;
   logic       tx_par;
   logic       tx_load;
   logic       tx_bit_end;
   logic       tx_last_stop;
   logic       tx_stop_end;

   assign tx_bit_end   = tx_tick && tx_tickcnt == TICK_LAST;
   assign tx_last_stop = !intclk[BIT_TWO_STOP] || tx_bitcnt == 4'h1;
   assign tx_stop_end  = tx_tick && (tx_tickcnt == ((tx_last_stop && intclk[BIT_SHORT_STOP])
                         ? TICK_SHORT_END : TICK_LAST));
   assign tx_load      = !tx_empty_flag && !sync_mode &&
                         (tx_state == TX_IDLE || (tx_state == TX_STOP && tx_stop_end && tx_last_stop));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_state   <= TX_IDLE;
         tx_shifter <= 9'h000;
         tx_tickcnt <= 4'h0;
         tx_bitcnt  <= 4'h0;
         tx_par     <= 1'b0;
         tx_line    <= 1'b1;
      end else if (tx_load) begin
         tx_state   <= TX_START;
         tx_shifter <= {ctrl[BIT_PARITY_SEL_LOW], tx_holding_reg};
         tx_par     <= parity_of({1'b0, tx_holding_reg & (fmt == FMT_SEVEN ? 8'h7f : 8'hff)}, par_sel);
         tx_tickcnt <= 4'h0;
         tx_bitcnt  <= 4'h0;
         tx_line    <= 1'b0;
      end else if (tx_tick) begin
         tx_tickcnt <= tx_tickcnt + 4'h1;
         case (tx_state)
            TX_START: if (tx_bit_end) begin
               tx_state <= TX_DATA;
               tx_line  <= tx_shifter[0];
            end
            TX_DATA: if (tx_bit_end) begin
               tx_shifter <= {1'b0, tx_shifter[8:1]};
               tx_bitcnt  <= tx_bitcnt + 4'h1;
               if (tx_bitcnt + 4'h1 == data_bits) begin
                  tx_bitcnt <= 4'h0;
                  tx_state  <= par_on ? TX_PAR : TX_STOP;
                  tx_line   <= par_on ? tx_par : 1'b1;
               end else begin
                  tx_line <= tx_shifter[1];
               end
            end
            TX_PAR: if (tx_bit_end) begin
               tx_state <= TX_STOP;
               tx_line  <= 1'b1;
            end
            TX_STOP: if (tx_stop_end) begin
               tx_tickcnt <= 4'h0;
               tx_bitcnt  <= tx_bitcnt + 4'h1;
               if (tx_last_stop) begin
                  tx_state <= TX_IDLE;
               end
            end
            default: tx_tickcnt <= 4'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_empty_flag  <= RESET_TX_EMPTY;
         tx_holding_reg <= 8'h00;
         tx_active      <= 1'b0;
      end else begin
         if (wr_txbuf) begin
            tx_holding_reg <= req.wdata;
            tx_empty_flag  <= 1'b0;
         end
         // Load beats a same-cycle write; software must wait for empty
         if (tx_load) begin
            tx_empty_flag <= 1'b1;
         end
         tx_active <= tx_load || (tx_state != TX_IDLE &&
                      !(tx_state == TX_STOP && tx_stop_end && tx_last_stop));
      end
   end

   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   rx_state_t  rx_state;
   logic [8:0] rx_shifter;
   logic [3:0] rx_tickcnt;
   logic [3:0] rx_bitcnt;
   logic       rx_par;
   logic       rx_mid;
   logic       rx_done;
   logic       rx_fe;
   logic       rx_pe;
   logic [8:0] rx_word;

   assign rx_mid  = rx_tick && rx_tickcnt == TICK_LAST;
   assign rx_done = rx_mid && rx_state == RX_STOP;
   assign rx_fe   = rx_done && !rx_line;
   assign rx_word = (fmt == FMT_SEVEN) ? {2'h0, rx_shifter[8:2]} :
                    nine_bit ? rx_shifter : {1'b0, rx_shifter[8:1]};
   assign rx_pe   = rx_done && par_on && (rx_par != parity_of({1'b0, rx_word[7:0]}, par_sel));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_state   <= RX_IDLE;
         rx_shifter <= 9'h000;
         rx_tickcnt <= 4'h0;
         rx_bitcnt  <= 4'h0;
         rx_par     <= 1'b0;
      end else if (rx_tick && !sync_mode) begin
         rx_tickcnt <= rx_tickcnt + 4'h1;
         case (rx_state)
            RX_IDLE: begin
               rx_tickcnt <= 4'h0;
               if (!rx_line && !rx_break_status) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: if (rx_tickcnt == TICK_HALF) begin
               rx_tickcnt <= 4'h0;
               rx_state   <= rx_line ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_mid) begin
               rx_shifter <= {rx_line, rx_shifter[8:1]};
               rx_bitcnt  <= rx_bitcnt + 4'h1;
               if (rx_bitcnt + 4'h1 == data_bits) begin
                  rx_bitcnt <= 4'h0;
                  rx_state  <= par_on ? RX_PAR : RX_STOP;
               end
            end
            RX_PAR: if (rx_mid) begin
               rx_par   <= rx_line;
               rx_state <= RX_STOP;
            end
            RX_STOP: if (rx_mid) begin
               rx_state <= RX_IDLE;
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // Hardware set wins over a same-cycle read clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_holding_reg   <= 8'h00;
         rx_full_flag     <= 1'b0;
         overrun_flag     <= 1'b0;
         framing_flag     <= 1'b0;
         parity_err_flag  <= 1'b0;
         rx_ninth_bit     <= 1'b0;
         attention_enable <= 1'b0;
         rx_break_status  <= 1'b0;
      end else begin
         if (rd_rxbuf) begin
            rx_full_flag <= 1'b0;
         end
         if (rd_rxstat) begin
            overrun_flag    <= 1'b0;
            framing_flag    <= 1'b0;
            parity_err_flag <= 1'b0;
         end
         if (wr_rxstat) begin
            attention_enable <= req.wdata[BIT_ATTENTION];
         end
         if (rx_done) begin
            rx_holding_reg <= rx_word[7:0];
            rx_full_flag   <= 1'b1;
            if (nine_bit) begin
               rx_ninth_bit <= rx_word[8];
               if (rx_word[8]) begin
                  attention_enable <= 1'b0;
               end
            end
            if (rx_full_flag && !rd_rxbuf) begin
               overrun_flag <= 1'b1;
            end
         end
         if (rx_fe) begin
            framing_flag    <= 1'b1;
            rx_break_status <= 1'b1;
         end else if (rx_line) begin
            rx_break_status <= 1'b0;
         end
         if (rx_pe) begin
            parity_err_flag <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Pin and interrupt outputs
   // ------------------------------------------------------------
   // Pin released when disabled so port logic can hold it low for a break
   always_comb begin
      line_out.serial_out_pin = tx_line;
      line_out.serial_out_oe  = intclk[BIT_TX_PIN_ENABLE];
      line_out.tx_irq = tx_empty_flag && intclk[BIT_TX_INT_ENABLE];
      line_out.rx_irq = rx_full_flag && intclk[BIT_RX_INT_ENABLE];
   end

endmodule

// *** src/usart_pkg.sv ***
// Package: register map, field positions, reset values and types for the serial core
package usart_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'hba;
   localparam logic [7:0] ADDR_RX_STATUS   = 8'hbb;
   localparam logic [7:0] ADDR_INT_CLK_SEL = 8'hbc;
   localparam logic [7:0] ADDR_TX_HOLD     = 8'hbd;
   localparam logic [7:0] ADDR_RX_HOLD     = 8'hbe;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_PARITY_ENABLE   = 7;
   localparam int BIT_PARITY_SEL_HIGH = 6;
   localparam int BIT_PARITY_SEL_LOW  = 5;
   localparam int BIT_FRAME_LEN_HIGH  = 4;
   localparam int BIT_FRAME_LEN_LOW   = 3;
   localparam int BIT_ERROR_ANY       = 2;
   localparam int BIT_RX_FULL         = 1;
   localparam int BIT_TX_EMPTY        = 0;

   localparam int BIT_OVERRUN         = 7;
   localparam int BIT_FRAMING         = 6;
   localparam int BIT_PARITY_ERR      = 5;
   localparam int BIT_SPARE           = 4;
   localparam int BIT_RX_NINTH        = 3;
   localparam int BIT_ATTENTION       = 2;
   localparam int BIT_TX_ACTIVE       = 1;
   localparam int BIT_RX_BREAK        = 0;

   localparam int BIT_TWO_STOP        = 7;
   localparam int BIT_SHORT_STOP      = 6;
   localparam int BIT_TX_PIN_ENABLE   = 5;
   localparam int BIT_SYNC_MODE       = 4;
   localparam int BIT_RX_EXT_CLOCK    = 3;
   localparam int BIT_TX_EXT_CLOCK    = 2;
   localparam int BIT_RX_INT_ENABLE   = 1;
   localparam int BIT_TX_INT_ENABLE   = 0;

   // ------------------------------------------------------------
   // Reset values and counts
   // ------------------------------------------------------------
   localparam logic [7:0] RESET_CTRL     = 8'h00;
   localparam logic [7:0] RESET_RXSTAT   = 8'h00;
   localparam logic [7:0] RESET_INTCLK   = 8'h00;
   localparam logic       RESET_TX_EMPTY = 1'b1;
   localparam int         OVERSAMPLE     = 16;
   localparam logic [3:0] TICK_LAST      = 4'hf;
   localparam logic [3:0] TICK_HALF      = 4'h7;
   localparam logic [3:0] TICK_SHORT_END = 4'hd;
   localparam logic [1:0] FMT_EIGHT      = 2'h0;
   localparam logic [1:0] FMT_SEVEN      = 2'h1;
   localparam logic [1:0] FMT_NINE       = 2'h2;
   localparam logic [1:0] FMT_LOOP       = 2'h3;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   typedef struct packed {
      logic serial_in_pin;
      logic ext_clock_pin;
   } line_in_t;

   typedef struct packed {
      logic serial_out_pin;
      logic serial_out_oe;
      logic tx_irq;
      logic rx_irq;
   } line_out_t;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

// *** bench/usart_core_sva.sv ***
// Checker: port-level properties of the serial core
`timescale 1ns/1ps
module usart_core_sva (
   input wire logic                 clk,
   input wire logic                 rstn,
   input wire usart_pkg::reg_req_t  req,
   input wire logic [7:0]           rdata,
   input wire logic                 baud_tick16,
   input wire usart_pkg::line_in_t  line_in,
   input wire usart_pkg::line_out_t line_out,
   input wire logic                 sync_mode
);
   import usart_pkg::*;
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   logic [7:0] cfg;
   logic [7:0] low_ticks;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) cfg <= 8'h00;
      else if (req.wr && req.addr == ADDR_INT_CLK_SEL) cfg <= req.wdata;
   end
   // Ticks seen while line low; every low run is whole bits
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) low_ticks <= 8'h00;
      else if (line_out.serial_out_pin) low_ticks <= 8'h00;
      else if (baud_tick16) low_ticks <= low_ticks + 8'h01;
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_tx_irq_mask; !cfg[BIT_TX_INT_ENABLE] |-> !line_out.tx_irq; endproperty
   a_tx_irq_mask: assert property (p_tx_irq_mask) else $error("tx irq while disabled");
   property p_rx_irq_mask; !cfg[BIT_RX_INT_ENABLE] |-> !line_out.rx_irq; endproperty
   a_rx_irq_mask: assert property (p_rx_irq_mask) else $error("rx irq while disabled");
   property p_pin_owner; line_out.serial_out_oe == cfg[BIT_TX_PIN_ENABLE]; endproperty
   a_pin_owner: assert property (p_pin_owner) else $error("pin enable mismatch");
   property p_mode; sync_mode == cfg[BIT_SYNC_MODE]; endproperty
   a_mode: assert property (p_mode) else $error("mode select mismatch");
   property p_empty_clear;
      req.wr && req.addr == ADDR_TX_HOLD && cfg[BIT_TX_INT_ENABLE] |=> !line_out.tx_irq;
   endproperty
   a_empty_clear: assert property (p_empty_clear) else $error("empty flag kept after write");
   property p_full_clear; req.rd && req.addr == ADDR_RX_HOLD |=> !line_out.rx_irq; endproperty
   a_full_clear: assert property (p_full_clear) else $error("full flag kept after read");
   sequence s_stat_rd; req.rd && req.addr == ADDR_RX_STATUS; endsequence
   property p_sticky_clear; s_stat_rd ##1 s_stat_rd |=> rdata[7:5] == 3'h0; endproperty
   a_sticky_clear: assert property (p_sticky_clear) else $error("error flags not cleared");
   property p_bit_ticks;
      $rose(line_out.serial_out_pin) |-> low_ticks[3:0] == 4'h0 && low_ticks != 8'h00;
   endproperty
   a_bit_ticks: assert property (p_bit_ticks) else $error("low run not whole bits");
   property p_reset_irq; $rose(rstn) |-> !line_out.tx_irq && !line_out.rx_irq; endproperty
   a_reset_irq: assert property (p_reset_irq) else $error("irq after reset");
   c_tx_frame: cover property ($fell(line_out.serial_out_pin));
   c_rx_full: cover property ($rose(line_out.rx_irq));
   c_stat_pair: cover property (s_stat_rd ##1 s_stat_rd);
endmodule

bind usart_core usart_core_sva i_sva (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
   .baud_tick16(baud_tick16), .line_in(line_in), .line_out(line_out), .sync_mode(sync_mode));

// *** bench/remote_serial.sv ***
// Partner: remote asynchronous station on the serial line
`timescale 1ns/1ps
module remote_serial (
   input  wire logic clk,
   input  wire logic tick,
   input  wire logic from_dut,
   output logic      to_dut
);
   logic [9:0] got;
   int         n_got;
   initial begin
      to_dut = 1'b1;
      n_got = 0;
   end
   // Mid-bit sampling; only the start edge realigns, so no drift
   always begin
      @(negedge from_dut);
      repeat (8) @(posedge clk iff tick);
      for (int i = 0; i < 10; i++) begin
         repeat (16) @(posedge clk iff tick);
         got[i] = from_dut;
      end
      n_got++;
   end
   // Start, n bits LSB first, last one the single stop; idle high after
   task automatic send(input logic [9:0] bits, input int n);
      @(posedge clk iff tick);
      to_dut <= 1'b0;
      for (int i = 0; i < n; i++) begin
         repeat (16) @(posedge clk iff tick);
         to_dut <= bits[i];
      end
      repeat (16) @(posedge clk iff tick);
      to_dut <= 1'b1;
   endtask
endmodule

// *** bench/testbench.sv ***
// Testbench: register, frame and error scenarios for the serial core
`timescale 1ns/1ps
module testbench;
   import usart_pkg::*;
   logic        clk;
   logic        rstn;
   logic        baud_tick16;
   logic        ext_clk;
   logic        rx_line;
   reg_req_t    req;
   logic [7:0]  rdata;
   line_in_t    line_in;
   line_out_t   line_out;
   logic        sync_mode;
   int          n_errors;
   int          comparisons;
   logic [31:0] seed;
   logic [7:0]  c;
   logic [7:0]  v;
   logic [9:0]  f;
   logic [9:0]  m;
   int          n0;
   assign line_in = '{serial_in_pin: rx_line, ext_clock_pin: ext_clk};
   always #5 clk = ~clk;
   always @(posedge clk) baud_tick16 <= ~baud_tick16;
   always @(posedge clk) ext_clk <= ~ext_clk;
   usart_core i_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .baud_tick16(baud_tick16),
      .line_in(line_in), .line_out(line_out), .sync_mode(sync_mode));
   remote_serial i_remote (.clk(clk), .tick(baud_tick16), .from_dut(line_out.serial_out_pin),
      .to_dut(rx_line));
   // ------------------------------------------------------------
   // Expectations
   // ------------------------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic int dbits(input logic [7:0] k);
      return (k[4:3] == FMT_EIGHT) ? 8 : (k[4:3] == FMT_SEVEN) ? 7 : 9;
   endfunction
   function automatic int nbits(input logic [7:0] k);
      return dbits(k) + ((k[7] && dbits(k) < 9) ? 1 : 0) + 1;
   endfunction
   // Data LSB first, optional parity, stop; ninth bit comes from the shared bit
   function automatic logic [9:0] frame(input logic [7:0] d, input logic [7:0] k);
      logic [8:0] w;
      logic [9:0] r;
      w = {k[5], d} & 9'((1 << dbits(k)) - 1);
      r = 10'h3ff;
      for (int i = 0; i < dbits(k); i++) r[i] = w[i];
      if (nbits(k) > dbits(k) + 1) r[dbits(k)] = k[6] ? ~k[5] : (k[5] ? ^w : ~^w);
      return r;
   endfunction
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1 d = rdata;
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] k);
      logic [7:0] d;
      rd(a, d);
      check({2'b00, d & k}, {2'b00, e & k});
   endtask
   task automatic wait_rx;
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk);
         if (line_out.rx_irq === 1'b1) return;
      end
      n_errors++;
      conclude();
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rstn = 1'b0;
      baud_tick16 = 1'b0;
      ext_clk = 1'b0;
      req = '0;
      n_errors = 0;
      comparisons = 0;
      seed = 32'h311a1263;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      expect_reg(ADDR_CTRL_STATUS, 8'h01, 8'hff);
      expect_reg(ADDR_RX_STATUS, RESET_RXSTAT, 8'hff);
      expect_reg(ADDR_INT_CLK_SEL, RESET_INTCLK, 8'hff);
      expect_reg(8'hc0, 8'h00, 8'hff);
      wr(ADDR_CTRL_STATUS, 8'h07);
      expect_reg(ADDR_CTRL_STATUS, 8'h01, 8'hff);
      wr(ADDR_INT_CLK_SEL, 8'h10);
      #1 check({9'h000, sync_mode}, 10'h001);
      wr(ADDR_INT_CLK_SEL, 8'h23);
      #1 check({9'h000, line_out.tx_irq}, 10'h001);
      // Every length and parity code; stop options drawn at random
      for (int i = 0; i < 16; i++) begin
         seed = xorshift(seed);
         c = {i < 12, 2'(i % 4), 2'(i % 3), 3'b000};
         wr(ADDR_INT_CLK_SEL, {seed[1:0], 6'h23});
         wr(ADDR_CTRL_STATUS, c);
         n0 = i_remote.n_got;
         wr(ADDR_TX_HOLD, seed[15:8]);
         for (int k = 0; k < 800 && i_remote.n_got == n0; k++) @(posedge clk);
         if (i_remote.n_got == n0) begin
            n_errors++;
            conclude();
         end
         m = 10'((1 << nbits(c)) - 1);
         check(i_remote.got & m, frame(seed[15:8], c) & m);
         for (int k = 0; k < 100; k++) begin
            rd(ADDR_RX_STATUS, v);
            if (v[1] === 1'b0) break;
         end
         check({9'h000, v[1]}, 10'h000);
         if (v[1] !== 1'b0) conclude();
         i_remote.send(frame(seed[15:8], c), nbits(c));
         wait_rx();
         expect_reg(ADDR_RX_HOLD, seed[15:8] & 8'((1 << dbits(c)) - 1), 8'hff);
         expect_reg(ADDR_RX_STATUS, {4'h0, c[5], 3'h0}, dbits(c) == 9 ? 8'hff : 8'hf7);
      end
      // Parity, framing and overrun faults in even parity
      c = 8'ha0;
      wr(ADDR_CTRL_STATUS, c);
      i_remote.send(frame(8'ha5, c) ^ 10'h100, 10);
      wait_rx();
      expect_reg(ADDR_CTRL_STATUS, 8'h04, 8'h04);
      @(posedge clk);
      req <= '{addr: ADDR_RX_STATUS, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      @(posedge clk);
      req <= '0;
      #1 check({7'h00, rdata[7:5]}, 10'h000);
      rd(ADDR_RX_HOLD, v);
      i_remote.send(frame(8'h3c, c) & 10'h1ff, 10);
      wait_rx();
      // Line high again passes two synchroniser stages first
      repeat (4) @(posedge clk);
      expect_reg(ADDR_RX_STATUS, 8'h40, 8'he1);
      rd(ADDR_RX_HOLD, v);
      i_remote.send(frame(8'h11, c), 10);
      i_remote.send(frame(8'h22, c), 10);
      wait_rx();
      expect_reg(ADDR_RX_STATUS, 8'h80, 8'h80);
      rd(ADDR_RX_HOLD, v);
      // Attention drops on a ninth bit of one
      c = 8'h30;
      wr(ADDR_CTRL_STATUS, c);
      wr(ADDR_RX_STATUS, 8'h04);
      expect_reg(ADDR_RX_STATUS, 8'h04, 8'h04);
      i_remote.send(frame(8'h55, c), 10);
      wait_rx();
      expect_reg(ADDR_RX_STATUS, 8'h08, 8'h0c);
      // Loop-back in nine-bit format, receiver on the external clock
      expect_reg(ADDR_RX_HOLD, 8'h55, 8'hff);
      wr(ADDR_INT_CLK_SEL, 8'h2b);
      wr(ADDR_CTRL_STATUS, 8'h38);
      wr(ADDR_TX_HOLD, 8'h96);
      wait_rx();
      expect_reg(ADDR_RX_HOLD, 8'h96, 8'hff);
      expect_reg(ADDR_RX_STATUS, 8'h08, 8'h08);
      conclude();
   end
endmodule
